// file: design/mptb_pkg.sv
// Package for the motor PWM time base: register map, fields, reset values.
// Assumes a single 50 MHz APB clock and 32-bit APB data.
package mptb_pkg;
  localparam logic [7:0]  MPTB_OFS_CONTROL = 8'h00;
  localparam logic [7:0]  MPTB_OFS_COUNTER = 8'h04;
  localparam logic [7:0]  MPTB_OFS_PERIOD  = 8'h08;
  localparam logic [7:0]  MPTB_OFS_DUTY1   = 8'h0C;
  localparam logic [7:0]  MPTB_OFS_DUTY2   = 8'h10;
  localparam logic [7:0]  MPTB_OFS_DUTY3   = 8'h14;
  localparam logic [7:0]  MPTB_OFS_STATUS  = 8'h18;
  // Control field positions.
  localparam int MPTB_CTL_MODE_LSB  = 0;
  localparam int MPTB_CTL_PRE_LSB   = 2;
  localparam int MPTB_CTL_POST_LSB  = 4;
  localparam int MPTB_CTL_UPDATE_DISABLE_BIT  = 14;
  localparam int MPTB_CTL_RUN_BIT   = 15;
  localparam int MPTB_CNT_DIR_BIT   = 15;
  // Reset values.
  localparam logic [14:0] MPTB_RST_COUNT  = 15'h0000;
  localparam logic [14:0] MPTB_RST_PERIOD = 15'h0000;
  localparam logic [15:0] MPTB_RST_DUTY   = 16'h0000;
  // Cycle clock is the oscillator divided by four: one pclk each.
  localparam int MPTB_CYC_DIV = 1;
  // Counting modes.
  typedef enum logic [1:0] {
    MPTB_FREE   = 2'h0,
    MPTB_SINGLE = 2'h1,
    MPTB_UPDN   = 2'h2,
    MPTB_DOUBLE = 2'h3
  } mptb_mode_e;
  // Prescale terminal value for each two-bit ratio selector.
  function automatic logic [5:0] mptb_pre_top(input logic [1:0] sel);
    case (sel)
      2'h0:    mptb_pre_top = 6'h00;
      2'h1:    mptb_pre_top = 6'h03;
      2'h2:    mptb_pre_top = 6'h0F;
      default: mptb_pre_top = 6'h3F;
    endcase
  endfunction
endpackage

// file: design/mptb_if.sv
// Interface carrying counter state from the time base to the duty stage.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface mptb_tb_if;
  logic [14:0] count;
  logic [14:0] period;
  logic        wrap;
  logic        running;
  logic        edge_mode;
  logic        update_disable;
  modport src (output count, period, wrap, running, edge_mode, update_disable);
  modport dst (input count, period, wrap, running, edge_mode, update_disable);
endinterface

// file: design/mptb_duty.sv
// One duty generator with buffered duty value and a high/low output pair.
// Assumes time base signals arrive from logic on the same clock.
`timescale 1ns/1ps
module mptb_duty
  import mptb_pkg::*;
(
  // Clock and reset.
  input  wire logic    pclk,
  input  wire logic    presetn,
  // Time base.
  mptb_tb_if.dst       tb,
  // Buffered duty from software.
  input  wire logic [15:0] duty_buf,
  // Pair outputs.
  output logic         high_out,
  output logic         low_out
);
  typedef struct packed {
    logic [15:0] duty;
    logic        hi;
  } mptb_duty_s;
  mptb_duty_s st_reg;
  mptb_duty_s st_next;

  // Active duty loads at wrap, or continuously while stopped unless blocked.
  always_comb begin
    st_next = st_reg;
    if (tb.wrap || (!tb.running && !tb.update_disable)) begin
      st_next.duty = duty_buf;
    end
    // Stopped pairs hold high off and low on; edge mode compares against the count.
    if (!tb.running || !tb.edge_mode) begin
      st_next.hi = 1'b0;
    end else if (st_next.duty == 16'h0000) begin
      st_next.hi = 1'b0;
    end else if (st_next.duty > {1'b0, tb.period}) begin
      st_next.hi = 1'b1;
    end else if (st_next.duty == {1'b0, tb.count}) begin
      st_next.hi = 1'b0;
    end else if (tb.count == 15'h0000) begin
      st_next.hi = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign high_out = st_reg.hi;
  assign low_out  = ~st_reg.hi;
endmodule

// file: design/mptb_top.sv
// Motor PWM time base with edge-aligned duty outputs behind an APB slave.
// Assumes a single 50 MHz pclk; outputs drive an external gate driver.
`timescale 1ns/1ps
module mptb_top
  import mptb_pkg::*;
(
  // APB slave.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Time base event, one-cycle pulse.
  output logic             tb_event,
  // Output pairs.
  output logic [2:0]       pair_high_out,
  output logic [2:0]       pair_low_out
);
  typedef struct packed {
    logic        run;
    logic        update_disable;
    logic [1:0]  mode;
    logic [1:0]  pre_sel;
    logic [3:0]  post_sel;
    logic [14:0] count;
    logic        dir;
    logic [14:0] period;
    logic [14:0] period_buf;
    logic [47:0] duty_buf;
    logic [5:0]  pre_cnt;
    logic [3:0]  post_cnt;
    logic        evt;
    logic        err;
    logic [31:0] rdata;
  } mptb_top_s;
  mptb_top_s st_reg;
  mptb_top_s st_next;

  mptb_tb_if tbi ();

  logic        acc;
  logic        wr;
  logic        tick;
  logic        match;
  logic        at_zero;
  logic        wrap;
  logic        raw_evt;
  logic        post_evt;
  logic        mapped;
  logic [31:0] rd_mux;

  // APB answers in the access cycle itself, no wait states.
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Terminal count of the prescaler gates every counter step.
  assign tick    = st_reg.run &&
                   (st_reg.pre_cnt == mptb_pre_top(st_reg.pre_sel));
  assign match   = (st_reg.count == st_reg.period) &&
                   (st_reg.period != 15'h0000);
  assign at_zero = (st_reg.count == 15'h0000);
  // Edge modes wrap after match; up/down modes never wrap.
  assign wrap    = tick && match && !st_reg.mode[1];

  // Event source per mode; period zero suppresses all of them.
  always_comb begin
    raw_evt = 1'b0;
    if (tick && st_reg.period != 15'h0000) begin
      case (mptb_mode_e'(st_reg.mode))
        MPTB_FREE:   raw_evt = match;
        MPTB_SINGLE: raw_evt = match;
        MPTB_UPDN:   raw_evt = at_zero && st_reg.dir;
        MPTB_DOUBLE: raw_evt = (match && !st_reg.dir) ||
                               (at_zero && st_reg.dir);
        default:     raw_evt = 1'b0;
      endcase
    end
  end

  // Postscale applies only to free-running and plain up/down (MPTB_UPDN) modes.
  assign post_evt = raw_evt &&
    ((st_reg.mode == MPTB_SINGLE) || (st_reg.mode == MPTB_DOUBLE) ||
     (st_reg.post_cnt == st_reg.post_sel));

  // Register read mux; unused bits read as zero.
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      MPTB_OFS_CONTROL: begin
        rd_mux[MPTB_CTL_RUN_BIT]  = st_reg.run;
        rd_mux[MPTB_CTL_UPDATE_DISABLE_BIT] = st_reg.update_disable;
        rd_mux[MPTB_CTL_POST_LSB +: 4] = st_reg.post_sel;
        rd_mux[MPTB_CTL_PRE_LSB +: 2]  = st_reg.pre_sel;
        rd_mux[MPTB_CTL_MODE_LSB +: 2] = st_reg.mode;
      end
      MPTB_OFS_COUNTER: rd_mux[15:0] = {st_reg.dir, st_reg.count};
      MPTB_OFS_PERIOD:  rd_mux[14:0] = st_reg.period_buf;
      MPTB_OFS_DUTY1:   rd_mux[15:0] = st_reg.duty_buf[15:0];
      MPTB_OFS_DUTY2:   rd_mux[15:0] = st_reg.duty_buf[31:16];
      MPTB_OFS_DUTY3:   rd_mux[15:0] = st_reg.duty_buf[47:32];
      MPTB_OFS_STATUS:  rd_mux[14:0] = st_reg.period;
      default:          mapped = 1'b0;
    endcase
  end

  // Next state: counter, scalers, period buffer and register writes.
  always_comb begin
    st_next     = st_reg;
    st_next.evt = post_evt;
    // Prescaler advances every cycle clock while running.
    if (st_reg.run) begin
      st_next.pre_cnt = tick ? 6'h00 : st_reg.pre_cnt + 6'h01;
    end
    // Postscaler counts raw events in every mode, scaled or not.
    if (raw_evt) begin
      st_next.post_cnt = (st_reg.post_cnt == st_reg.post_sel) ?
                         4'h0 : st_reg.post_cnt + 4'h1;
    end
    // Counter stepping; a cleared run bit simply freezes it.
    if (tick && st_reg.period != 15'h0000) begin
      if (!st_reg.mode[1]) begin
        if (match) begin
          st_next.count = 15'h0000;
          if (st_reg.mode == MPTB_SINGLE) begin
            st_next.run = 1'b0;
          end
        end else begin
          st_next.count = st_reg.count + 15'h0001;
        end
        st_next.dir = 1'b0;
      end else if (st_reg.dir) begin
        // Turning points dwell one tick so a full cycle is twice period+1.
        if (at_zero) begin
          st_next.dir = 1'b0;
        end else begin
          st_next.count = st_reg.count - 15'h0001;
        end
      end else if (match) begin
        st_next.dir = 1'b1;
      end else begin
        st_next.count = st_reg.count + 15'h0001;
      end
    end
    // Period buffer transfer points; a zero period waits for a stop.
    if (!st_reg.run) begin
      st_next.period = st_reg.period_buf;
    end else if (st_reg.period != 15'h0000) begin
      if (wrap || (st_reg.mode[1] && at_zero)) begin
        st_next.period = st_reg.period_buf;
      end
    end
    // Register writes; hardware run clear loses to a software set.
    if (wr) begin
      case (paddr)
        MPTB_OFS_CONTROL: begin
          st_next.run      = pwdata[MPTB_CTL_RUN_BIT];
          st_next.update_disable     = pwdata[MPTB_CTL_UPDATE_DISABLE_BIT];
          st_next.post_sel = pwdata[MPTB_CTL_POST_LSB +: 4];
          st_next.pre_sel  = pwdata[MPTB_CTL_PRE_LSB +: 2];
          st_next.mode     = pwdata[MPTB_CTL_MODE_LSB +: 2];
          st_next.pre_cnt  = 6'h00;
          st_next.post_cnt = 4'h0;
        end
        MPTB_OFS_COUNTER: begin
          st_next.count    = pwdata[14:0];
          st_next.pre_cnt  = 6'h00;
          st_next.post_cnt = 4'h0;
        end
        MPTB_OFS_PERIOD: st_next.period_buf = pwdata[14:0];
        MPTB_OFS_DUTY1:  st_next.duty_buf[15:0]  = pwdata[15:0];
        MPTB_OFS_DUTY2:  st_next.duty_buf[31:16] = pwdata[15:0];
        MPTB_OFS_DUTY3:  st_next.duty_buf[47:32] = pwdata[15:0];
        default: ;
      endcase
    end
    st_next.err   = 1'b0;
    st_next.rdata = (acc && !pwrite) ? rd_mux : st_reg.rdata;
  end

  // Reset clears every counter, flag and scaler.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data is combinational in the access cycle so the answer is taken
  // at the same edge; the registered copy only holds the last value.
  assign prdata   = (acc && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
  assign tb_event = st_reg.evt;

  // Time base view for the duty stages.
  assign tbi.count     = st_reg.count;
  assign tbi.period    = st_reg.period;
  assign tbi.wrap      = wrap;
  assign tbi.running   = st_reg.run;
  assign tbi.edge_mode = !st_reg.mode[1];
  assign tbi.update_disable      = st_reg.update_disable;

  // Three generators, one per pair.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_duty
      mptb_duty u_duty (
        .pclk     (pclk),
        .presetn  (presetn),
        .tb       (tbi),
        .duty_buf (st_reg.duty_buf[16*g +: 16]),
        .high_out (pair_high_out[g]),
        .low_out  (pair_low_out[g])
      );
    end
  endgenerate
endmodule

// file: verification/mptb_stage.sv
// Power stage model: counts on-time of each high switch in a window.
// Assumes it shares pclk with the PWM block it loads.
`timescale 1ns/1ps
module mptb_stage (
  // Clock and window.
  input  wire logic        pclk,
  input  wire logic        meas,
  // Gate drives.
  input  wire logic [2:0]  hi_in,
  input  wire logic [2:0]  lo_in,
  // Results.
  output logic [2:0][15:0] on_cnt,
  output logic             shoot
);
  logic meas_d = 1'b0;
  initial shoot = 1'b0;
  // Both switches of a leg on would short the supply, so it is latched.
  always @(posedge pclk) begin
    meas_d <= meas;
    if ((hi_in & lo_in) != 3'h0) shoot <= 1'b1;
    for (int i = 0; i < 3; i++)
      if (meas) on_cnt[i] <= (meas_d ? on_cnt[i] : 16'h0) + 16'(hi_in[i]);
  end
endmodule

// file: verification/mptb_props.sv
// Checker for the PWM time base, watching only the top-level ports.
// Assumes the register map of the package and zero-wait APB.
`timescale 1ns/1ps
module mptb_props
  import mptb_pkg::*;
(
  // Clock and APB.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Event and outputs.
  input wire logic        tb_event,
  input wire logic [2:0]  pair_high_out,
  input wire logic [2:0]  pair_low_out
);
  logic [15:0] ctl_sh;
  logic [14:0] pbuf_sh;
  logic [31:0] gap;
  logic [31:0] want;
  logic [1:0]  roff;
  logic [1:0]  zcnt;
  logic        ok;
  logic        ss_done;
  logic        zl;
  logic        wr;
  logic        ctl_wr;
  assign wr = psel & penable & pwrite & pready;
  assign ctl_wr = wr && paddr == MPTB_OFS_CONTROL;
  assign want = ((32'(pbuf_sh) + 32'h1) * (32'(ctl_sh[7:4]) + 32'h1))
                << (2 * ctl_sh[3:2]);
  // Shadows of software state; a write spoils the event spacing history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ctl_sh, pbuf_sh, gap, roff, zcnt, ok, ss_done, zl} <= '0;
    end else begin
      if (ctl_wr) ctl_sh <= pwdata[15:0];
      if (wr && paddr == MPTB_OFS_PERIOD) pbuf_sh <= pwdata[14:0];
      gap <= tb_event ? 32'h1 : gap + 32'h1;
      ok <= wr ? 1'b0 : (tb_event | ok);
      ss_done <= ctl_wr ? 1'b0 : (ss_done | (tb_event && ctl_sh[1:0] == 2'h1));
      roff <= ctl_sh[15] ? 2'h0 : (roff == 2'h3 ? roff : roff + 2'h1);
      zl <= ctl_sh[15] ? zl : (pbuf_sh == 15'h0);
      zcnt <= !zl ? 2'h0 : (zcnt == 2'h3 ? zcnt : zcnt + 2'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_low_complement:
    assert property (pair_low_out == ~pair_high_out) else $error("low not inverse");
  a_reset_quiet:
    assert property ($rose(presetn) |-> pair_high_out == 3'h0 && !tb_event)
    else $error("active right after reset");
  a_halt_quiet:
    assert property (roff == 2'h3 |-> !tb_event) else $error("event while halted");
  a_idle_outputs:
    assert property (roff == 2'h3 |-> pair_high_out == 3'h0)
    else $error("output active while halted");
  a_zero_period_quiet:
    assert property (zcnt == 2'h3 |-> !tb_event) else $error("event at period zero");
  a_single_once:
    assert property (ss_done |-> !tb_event) else $error("second single event");
  a_free_rate:
    assert property (tb_event && ok && ctl_sh[15] && ctl_sh[1:0] == 2'h0
      |-> gap == want) else $error("free event spacing wrong");
  a_dir_up_read:
    assert property (psel && penable && !pwrite && paddr == MPTB_OFS_COUNTER
      && ok && ctl_sh[1:0] == 2'h0 |-> prdata[31:15] == 17'h0)
    else $error("counter reads down in free mode");
  cover property (tb_event && ctl_sh[1:0] == 2'h0);
  cover property (tb_event && ctl_sh[1:0] == 2'h1);
  cover property (tb_event && ctl_sh[1:0] == 2'h3);
endmodule
bind mptb_top mptb_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .tb_event, .pair_high_out,
  .pair_low_out);

// file: verification/mptb_top_tb.sv
// Self-checking bench for the PWM time base with a power stage model.
// Assumes the package register map and a 50 MHz pclk.
`timescale 1ns/1ps
module mptb_top_tb
  import mptb_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, meas = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tb_event, shoot;
  logic [2:0] hi, lo;
  logic [2:0][15:0] on_cnt;
  logic [63:0] q[$];
  int n_fail = 0, cmp_count = 0, ev_n = 0, cyc = 0;
  int pre_t[5] = '{0, 1, 2, 3, 0}, post_t[5] = '{0, 1, 3, 1, 15};
  integer seed = 32'h895D7D97;
  mptb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tb_event, .pair_high_out(hi),
    .pair_low_out(lo));
  mptb_stage u_stage (.pclk, .meas, .hi_in(hi), .lo_in(lo), .on_cnt, .shoot);
  // Clock of 20 ns.
  initial begin
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Request held from setup until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    q.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask
  // Count events and on-time over exactly n edges.
  task automatic win(input int n, ev, on1, on2);
    ev_n = 0;
    @(posedge pclk);
    meas <= 1'b1;
    repeat (n) @(posedge pclk);
    meas <= 1'b0;
    @(posedge pclk);
    chk(ev_n, ev, "event count");
    chk(on_cnt[0], 32'h0, "zero duty on-time");
    chk(on_cnt[1], on1, "duty on-time");
    chk(on_cnt[2], on2, "full duty on-time");
    chk(shoot, 1'b0, "leg shoot-through");
  endtask
  // Reads are judged at their sampling edge; a hang ends the run.
  always @(posedge pclk) begin
    cyc++;
    if (meas && tb_event === 1'b1) ev_n++;
    if (cyc > 60000) begin
      n_fail++;
      end_sim;
    end else if (psel && penable && !pwrite && pready === 1'b1) begin
      chk(prdata & q[0][63:32], q[0][31:0], "read data");
      void'(q.pop_front());
    end
  end
  initial begin
    logic [31:0] d, pr, po, len;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, 32'hFFFFFFFF);
    $display("reset values done");
    apb(1'b1, MPTB_OFS_COUNTER, 32'h7);
    apb(1'b1, MPTB_OFS_CONTROL, 32'h2);
    repeat (20) @(posedge pclk);
    rd(MPTB_OFS_COUNTER, 32'h7, 32'hFFFF);
    apb(1'b1, MPTB_OFS_PERIOD, 32'hC);
    rd(MPTB_OFS_STATUS, 32'hC, 32'h7FFF);
    apb(1'b1, MPTB_OFS_PERIOD, 32'h0);
    apb(1'b1, MPTB_OFS_CONTROL, 32'h8000);
    apb(1'b1, MPTB_OFS_PERIOD, 32'h5);
    win(200, 0, 0, 0);
    rd(MPTB_OFS_STATUS, 32'h0, 32'h7FFF);
    apb(1'b1, MPTB_OFS_CONTROL, 32'h0);
    rd(MPTB_OFS_STATUS, 32'h5, 32'h7FFF);
    $display("halt and zero period done");
    for (int k = 0; k < 5; k++) begin
      pr = 32'h1 << (2 * pre_t[k]);
      po = 32'(post_t[k]) + 32'h1;
      d = 32'h1 + ({$random(seed)} % 32'h9);
      len = 32'hA * pr * po;
      apb(1'b1, MPTB_OFS_CONTROL, 32'h0);
      apb(1'b1, MPTB_OFS_PERIOD, 32'h9);
      apb(1'b1, MPTB_OFS_DUTY2, d);
      apb(1'b1, MPTB_OFS_DUTY3, 32'hA + ({$random(seed)} % 32'hFFF0));
      apb(1'b1, MPTB_OFS_CONTROL,
          32'h8000 | (post_t[k] << 4) | (pre_t[k] << 2));
      repeat (2 * len) @(posedge pclk);
      win(4 * len, 4, d * pr * 4 * po, 4 * len);
      rd(MPTB_OFS_COUNTER, 32'h0, 32'hFFFF8000);
    end
    $display("free run done");
    apb(1'b1, MPTB_OFS_CONTROL, 32'h0);
    apb(1'b1, MPTB_OFS_DUTY2, 32'h0);
    apb(1'b1, MPTB_OFS_DUTY3, 32'h0);
    apb(1'b1, MPTB_OFS_CONTROL, 32'h8031);
    win(300, 1, 0, 0);
    rd(MPTB_OFS_CONTROL, 32'h31, 32'hFFFF);
    rd(MPTB_OFS_COUNTER, 32'h0, 32'h7FFF);
    $display("single shot done");
    apb(1'b1, MPTB_OFS_CONTROL, 32'h8012);
    repeat (100) @(posedge pclk);
    win(160, 4, 0, 0);
    // Period stays at nine, well clear of one.
    apb(1'b1, MPTB_OFS_CONTROL, 32'h8033);
    repeat (100) @(posedge pclk);
    win(80, 8, 0, 0);
    $display("up down done");
    end_sim;
  end
endmodule
